/* core/ext_bus_cycle_sequencer.v */
`default_nettype none
`include "bus_seq_consts.vh"
module ext_bus_cycle_sequencer (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        req_valid,
  input  wire [2:0]  req_area,
  input  wire        req_write,
  input  wire        req_word,
  input  wire [15:0] req_wdata,
  input  wire [5:0]  req_burst_count,
  input  wire [15:0] ext_rdata,
  input  wire        wait_pin_n,
  input  wire [15:0] area_if_type,
  input  wire [7:2]  area_little_endian_select,
  input  wire [7:0]  access_state_control_reg,
  input  wire [23:0] wait_count_reg,
  input  wire [7:0]  chip_select_assert_ctrl,
  input  wire [2:0]  burst_cycle_count_field,
  input  wire [7:0]  address_phase_extend_bit,
  input  wire [7:0]  bus_width_16,
  output reg         busy,
  output reg         done,
  output reg  [15:0] rdata,
  output reg  [3:0]  bus_state,
  output reg         cs_active,
  output reg         ext_data_oe_n,
  output reg  [15:0] ext_wdata,
  output reg  [7:0]  endian_control_reg
);
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [2:0]  area;
  reg         wr;
  reg         word;
  reg  [15:0] wdat;
  reg  [5:0]  bursts_left;
  reg  [2:0]  cnt;
  reg         wait_s1;
  reg         wait_s2;
  reg  [1:0]  cur_if;
  reg         three_st;
  reg         lead_en;
  reg         trail_en;
  reg  [2:0]  pwaits;
  reg         swap;
  reg         wide;
  reg         last_state;
  reg  [15:0] rd_fix;
  reg  [2:0]  sel_area;
  reg         sel_wr;
  reg         sel_word;
  reg  [15:0] sel_wdat;
  reg         data_swap;
  reg  [15:0] next_ext_wdata;
  reg         next_data_oe_n;
  always @*
  begin
    // idle: decode the incoming request so its first data state is steered right
    sel_area = (state == `ST_IDLE) ? req_area : area;
    sel_wr   = (state == `ST_IDLE) ? req_write : wr;
    sel_word = (state == `ST_IDLE) ? req_word : word;
    sel_wdat = (state == `ST_IDLE) ? req_wdata : wdat;
    cur_if   = area_if_type[sel_area*2 +: 2];
    three_st = access_state_control_reg[sel_area];
    lead_en  = chip_select_assert_ctrl[sel_area];
    trail_en = chip_select_assert_ctrl[sel_area] && (cur_if != `IF_BURST_ROM);
    pwaits   = wait_count_reg[sel_area*3 +: 3];
    swap     = (sel_area >= 3'h2) && endian_control_reg[sel_area];
    wide     = (cur_if == `IF_BYTE_SRAM) ? 1'b1 : bus_width_16[sel_area];
    data_swap = swap && sel_word && wide;
    rd_fix   = data_swap ? {ext_rdata[7:0], ext_rdata[15:8]} : ext_rdata;
  end
  always @*
  begin
    next_state = state;
    last_state = 1'b0;
    case (state)
      `ST_IDLE:
        if (req_valid)
          next_state = (area_if_type[req_area*2 +: 2] == `IF_MUX) ? `ST_ADDR :
                       (chip_select_assert_ctrl[req_area] ? `ST_LEAD : `ST_FIRST);
      `ST_ADDR:
        if (cnt == 3'h0)
          next_state = lead_en ? `ST_LEAD : `ST_FIRST;
      `ST_LEAD:
        next_state = `ST_FIRST;
      `ST_FIRST:
        next_state = `ST_SECOND;
      `ST_SECOND:
        if (!three_st)
        begin
          if (cur_if == `IF_BURST_ROM && bursts_left != 6'h0)
            next_state = `ST_BURST;
          else if (trail_en)
            next_state = `ST_TRAIL;
          else
            last_state = 1'b1;
        end
        else if (pwaits != 3'h0)
          next_state = `ST_PWAIT;
        // pin reaches here two cycles late: pin waits need a lead state or a programmed wait ahead
        else if (wait_s2)
          next_state = `ST_XWAIT;
        else
          next_state = `ST_THIRD;
      `ST_PWAIT:
        if (cnt == 3'h0)
          next_state = wait_s2 ? `ST_XWAIT : `ST_THIRD;
      `ST_XWAIT:
        if (!wait_s2)
          next_state = `ST_THIRD;
      `ST_THIRD:
        if (cur_if == `IF_BURST_ROM && bursts_left != 6'h0)
          next_state = `ST_BURST;
        else if (trail_en)
          next_state = `ST_TRAIL;
        else
          last_state = 1'b1;
      `ST_TRAIL:
        last_state = 1'b1;
      `ST_BURST:
        if (cnt == 3'h0 && bursts_left == 6'h1)
          last_state = 1'b1;
      default:
        next_state = `ST_IDLE;
    endcase
    if (last_state)
      next_state = `ST_IDLE;
  end
  always @*
  begin
    // data lanes driven for writes in every state but idle and address, lead and trail included
    next_data_oe_n = ~(sel_wr && next_state != `ST_IDLE && next_state != `ST_ADDR);
    // lanes swap only for word transfers on a 16-bit little endian area
    next_ext_wdata = data_swap ? {sel_wdat[7:0], sel_wdat[15:8]} : sel_wdat;
  end
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= `ST_IDLE;
      area <= 3'h0;
      wr <= 1'b0;
      word <= 1'b0;
      wdat <= 16'h0000;
      bursts_left <= 6'h00;
      cnt <= 3'h0;
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      bus_state <= `ST_IDLE;
      cs_active <= 1'b0;
      ext_data_oe_n <= 1'b1;
      ext_wdata <= 16'h0000;
      endian_control_reg <= `ENDIAN_RESET;
    end
    else if (clk_en)
    begin
      // wait pin is asynchronous, two stages before use
      // clock enable low holds the synchroniser too
      wait_s1 <= ~wait_pin_n;
      wait_s2 <= wait_s1;
      endian_control_reg <= {area_little_endian_select, 2'b00};
      state <= next_state;
      bus_state <= next_state;
      busy <= (next_state != `ST_IDLE);
      cs_active <= (next_state != `ST_IDLE) && (next_state != `ST_ADDR);
      done <= last_state;
      // requests are taken from idle only; one raised while busy waits
      if (state == `ST_IDLE && req_valid)
      begin
        area <= req_area;
        wr <= req_write;
        word <= req_word;
        wdat <= req_wdata;
        bursts_left <= req_burst_count;
        // address phase counter preload: 2 or 3 states
        cnt <= address_phase_extend_bit[req_area] ? `ADDR_PRELOAD_LONG : `ADDR_PRELOAD_SHORT;
      end
      else if (next_state == `ST_PWAIT && state != `ST_PWAIT)
        cnt <= pwaits - 3'h1;
      else if (next_state == `ST_BURST && state != `ST_BURST)
        cnt <= burst_cycle_count_field;
      // each burst access reloads its length
      else if (state == `ST_BURST && cnt == 3'h0)
      begin
        cnt <= burst_cycle_count_field;
        bursts_left <= bursts_left - 6'h01;
      end
      else if (cnt != 3'h0)
        cnt <= cnt - 3'h1;
      ext_data_oe_n <= next_data_oe_n;
      ext_wdata <= next_ext_wdata;
      if (!wr && (last_state || (state == `ST_BURST && cnt == 3'h0)))
        rdata <= rd_fix;
    end
  end
endmodule // ext_bus_cycle_sequencer
`default_nettype wire

/* core/bus_seq_consts.vh */
`ifndef BUS_SEQ_CONSTS_VH
`define BUS_SEQ_CONSTS_VH
// interface type codes
`define IF_BASIC      2'h0
`define IF_BYTE_SRAM  2'h1
`define IF_BURST_ROM  2'h2
`define IF_MUX        2'h3
// state codes
`define ST_IDLE   4'h0
`define ST_ADDR   4'h1
`define ST_LEAD   4'h2
`define ST_FIRST  4'h3
`define ST_SECOND 4'h4
`define ST_PWAIT  4'h5
`define ST_XWAIT  4'h6
`define ST_THIRD  4'h7
`define ST_TRAIL  4'h8
`define ST_BURST  4'h9
// reset values
`define ENDIAN_RESET   8'h00
// address phase counter preloads: 2 or 3 states
`define ADDR_PRELOAD_SHORT 3'h1
`define ADDR_PRELOAD_LONG  3'h2
`endif

/* tb/ext_bus_cycle_sequencer_chk.sv */
`default_nettype none
`include "bus_seq_consts.vh"
module ext_bus_cycle_sequencer_chk (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       cs_active,
  input wire logic [3:0] bus_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_done_at_end: assert property ($fell(busy) |-> done) else $error("no done");
  chk_done_pulse: assert property (done |=> !done) else $error("long done");
  chk_first_second: assert property (bus_state == `ST_FIRST |=> bus_state == `ST_SECOND) else $error("order");
  chk_lead_first: assert property (bus_state == `ST_LEAD |=> bus_state == `ST_FIRST) else $error("lead");
  chk_wait_limit: assert property ((bus_state == `ST_PWAIT) [*7] |=> bus_state != `ST_PWAIT) else $error("waits");
  chk_wait_order: assert property (bus_state == `ST_PWAIT |=> bus_state inside {`ST_PWAIT, `ST_XWAIT, `ST_THIRD})
    else $error("wait");
  chk_trail_last: assert property (bus_state == `ST_TRAIL |=> done) else $error("trail");
  chk_cs_held: assert property (bus_state inside {[`ST_LEAD:`ST_TRAIL]} |-> cs_active) else $error("cs");
endmodule // ext_bus_cycle_sequencer_chk
bind ext_bus_cycle_sequencer ext_bus_cycle_sequencer_chk chk_u (.*);
`default_nettype wire

/* tb/ext_dev_model.sv */
`default_nettype none
module ext_dev_model (
  input  wire logic        clk_sys,
  input  wire logic        cs_active,
  input  wire logic        ext_data_oe_n,
  input  wire logic [15:0] ext_wdata,
  input  wire logic [7:0]  hold,
  input  wire logic [15:0] d,
  output logic      [15:0] ext_rdata,
  output logic      [15:0] wr_seen,
  output logic             wait_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cnt = 8'h00;
  logic [15:0] q = 16'h0000;
  // released bus never echoes old data
  assign ext_rdata = cs_active ? d : ~q;
  assign wait_pin_n = !(cs_active && cnt < hold);
  always @(posedge clk_sys)
  begin
    cnt <= cs_active ? cnt + 8'h01 : 8'h00;
    if (cs_active)
      q <= d;
    if (cs_active && !ext_data_oe_n)
      wr_seen <= ext_wdata;
  end
endmodule // ext_dev_model
`default_nettype wire

/* tb/ext_bus_cycle_sequencer_bench.sv */
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module ext_bus_cycle_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, req_valid = 1'h0, req_write = 1'h0, req_word = 1'h1;
  logic busy, done, cs_active, ext_data_oe_n;
  logic [1:0] t;
  logic [2:0] a, req_area = 3'h0, burst_cycle_count_field = 3'h0;
  logic [3:0] bus_state;
  logic [5:0] req_burst_count = 6'h00;
  logic [7:2] area_little_endian_select = 6'h3F;
  logic [7:0] bus_width_16 = 8'hFF, hold = 8'h00, access_state_control_reg = 8'h00, chip_select_assert_ctrl = 8'h00;
  logic [7:0] address_phase_extend_bit = 8'h00, endian_control_reg;
  logic [15:0] req_wdata = 16'h0000, area_if_type = 16'h0000, d = 16'h0000, rdata, ext_wdata;
  logic [23:0] wait_count_reg = 24'h000000;
  logic [31:0] sd = 32'h41CD;
  wire logic [15:0] ext_rdata, wr_seen;
  wire logic wait_pin_n;
  int error_cnt = 0, samples_checked = 0, k;
  logic [15:0] n;
  ext_bus_cycle_sequencer dut_u (.*);
  ext_dev_model dev_u (.*);
  always #2 clk_sys = ~clk_sys;
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int len(int r, int y);
    return (access_state_control_reg[r] ? 3 + wait_count_reg[3*r+:3] : 2)
      + chip_select_assert_ctrl[r] * (y == 2 ? 1 : 2) + (y == 3 ? 2 + address_phase_extend_bit[r] : 0)
      + (y == 2 ? req_burst_count * (burst_cycle_count_field + 1) : 0);
  endfunction
  task automatic run(logic [2:0] r, logic [7:0] h);
    logic [15:0] x;
    logic [15:0] y;
    hold <= h;
    req_area <= r;
    @(posedge clk_sys);
    req_valid <= 1'h1;
    @(posedge clk_sys);
    req_valid <= 1'h0;
    n = 16'h0000;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      n += busy;
      k++;
    end
    while (done !== 1'h1 && k < 1000);
    `CHK(done, 1'h1)
    x = (r > 1 && area_little_endian_select[r]) ? {d[7:0], d[15:8]} : d;
    y = (r > 1 && area_little_endian_select[r]) ? {req_wdata[7:0], req_wdata[15:8]} : req_wdata;
    if (req_write)
      `CHK(wr_seen, y)
    else
      `CHK(rdata, x)
    if (h == 0 || !access_state_control_reg[r])
      `CHK(n, len(r, area_if_type[2*r+:2]))
    else
      `CHK(n > len(r, area_if_type[2*r+:2]), 1'h1)
    @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(negedge clk_sys);
    `CHK({endian_control_reg, ext_data_oe_n, busy, done, cs_active, bus_state, rdata, ext_wdata}, 48'h008000000000)
    @(posedge clk_sys);
    run(3'h2, 8'h0F);
    access_state_control_reg <= 8'hFF;
    // two programmed waits let the synchronised pin be seen
    wait_count_reg <= 24'h000080;
    run(3'h2, 8'h0F);
    area_if_type <= 16'hAAAA;
    {req_burst_count, burst_cycle_count_field, chip_select_assert_ctrl} <= 17'h1FFFF;
    run(3'h0, 8'h00);
    clk_en <= 1'h0;
    area_little_endian_select <= 6'h15;
    repeat (2) @(negedge clk_sys);
    `CHK(endian_control_reg, 8'hFC)
    @(posedge clk_sys);
    clk_en <= 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK(endian_control_reg, 8'h54)
    @(posedge clk_sys);
    $display("corner tests done");
    repeat (200)
    begin
      sd = nx(sd);
      {t, a} = sd[4:0];
      // burst rom only in areas 0-1, muxed only in 3-7
      if (t == 2'h2 ? a > 1 : t == 2'h3 && a < 3)
        t = 2'h0;
      area_if_type <= {8{t}};
      {access_state_control_reg, chip_select_assert_ctrl, address_phase_extend_bit, area_little_endian_select} <= sd[31:2];
      sd = nx(sd);
      {wait_count_reg, burst_cycle_count_field, req_write, req_burst_count} <= {sd, 2'h0};
      sd = nx(sd);
      {d, req_wdata} <= sd;
      run(a, 8'h00);
    end
    $display("random tests done");
    stop_test;
  end
endmodule // ext_bus_cycle_sequencer_bench
`default_nettype wire
